// [design/data_eeprom_access_control.sv]
// Summary of operation
// - One data byte moves per access
// - Address is high register then low register
// - Byte write erases then programs location, data region only
// - Internal programming timer sets write time
// - Region field steers program, data, config space
// - Write allow gates writes, clear after reset
// - Error flag set on start, cleared on finish
// - Write start only cleared by hardware at end
// - Done flag set on finish, software clears
// - Read start self clears after read
// - Read start refused for program region
module data_eeprom_access_control
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Register port
    input  wire nvm_pkg::bus_req_t bus,
    output logic [7:0]           rdata,
    // Interrupt
    output logic                 irq,
    // Space selected for a read of the other regions
    output logic [1:0]           region_out,
    input  wire logic [7:0]      ext_rdata
);
    import nvm_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    state_t     state;
    state_t     next_state;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] data;
    logic [7:0] next_data;
    logic [7:0] addr_lo;
    logic [7:0] next_addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] next_addr_hi;
    logic [7:0] unlock;
    logic [7:0] next_unlock;
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic [7:0] next_rdata;
    logic       next_irq;
    logic [7:0] mem [DEPTH];
    logic       mem_we;
    logic [7:0] mem_wdata;
    logic [AW-1:0] mem_addr;
    logic       start_wr;
    logic       start_rd;

    logic [15:0] full_addr;

    assign full_addr = {addr_hi, addr_lo};
    // Upper address bits beyond the array are ignored
    assign mem_addr  = full_addr[AW-1:0];

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        next_state   = state;
        next_ctrl    = ctrl;
        next_data    = data;
        next_addr_lo = addr_lo;
        next_addr_hi = addr_hi;
        next_unlock  = unlock;
        next_status  = status;
        next_mask    = mask;
        next_timer   = timer;
        next_rdata   = RESET_BYTE;
        mem_we       = 1'b0;
        mem_wdata    = data;
        start_wr     = 1'b0;
        start_rd     = 1'b0;

        if (bus.wr && bus.addr == OFS_CONTROL)
        begin
            // Busy bits are left alone so software cannot cancel a cycle
            next_ctrl[BIT_WRITE_ALLOW] = bus.wdata[BIT_WRITE_ALLOW];
            next_ctrl[BIT_WRITE_ERROR] = ctrl[BIT_WRITE_ERROR] & bus.wdata[BIT_WRITE_ERROR];
            if (state == ST_IDLE)
            begin
                next_ctrl[BIT_REGION_LO +: 2] = bus.wdata[BIT_REGION_LO +: 2];
                if (bus.wdata[BIT_WRITE_START] && ctrl[BIT_WRITE_ALLOW])
                begin
                    start_wr = 1'b1;
                end
                else if (bus.wdata[BIT_READ_START]
                         && bus.wdata[BIT_REGION_LO +: 2] != REGION_PROG)
                begin
                    start_rd = 1'b1;
                end
            end
        end
        else if (bus.wr && bus.addr == OFS_UNLOCK)
        begin
            next_unlock = bus.wdata;
        end
        else if (bus.wr && bus.addr == OFS_DATA && state == ST_IDLE)
        begin
            next_data = bus.wdata;
        end
        else if (bus.wr && bus.addr == OFS_ADDR_LO && state == ST_IDLE)
        begin
            next_addr_lo = bus.wdata;
        end
        else if (bus.wr && bus.addr == OFS_ADDR_HI && state == ST_IDLE)
        begin
            next_addr_hi = bus.wdata;
        end
        else if (bus.wr && bus.addr == OFS_MASK)
        begin
            next_mask = bus.wdata;
        end

        if (bus.rd && bus.addr == OFS_CONTROL)
        begin
            next_rdata = ctrl;
        end
        else if (bus.rd && bus.addr == OFS_UNLOCK)
        begin
            next_rdata = RESET_BYTE;
        end
        else if (bus.rd && bus.addr == OFS_DATA)
        begin
            next_rdata = data;
        end
        else if (bus.rd && bus.addr == OFS_ADDR_LO)
        begin
            next_rdata = addr_lo;
        end
        else if (bus.rd && bus.addr == OFS_ADDR_HI)
        begin
            next_rdata = addr_hi;
        end
        else if (bus.rd && bus.addr == OFS_STATUS)
        begin
            next_rdata = status;
        end
        else if (bus.rd && bus.addr == OFS_MASK)
        begin
            next_rdata = mask;
        end

        // Done flag cleared only by status read
        if (bus.rd && bus.addr == OFS_STATUS)
        begin
            next_status = RESET_BYTE;
        end

        case (state)
            ST_IDLE:
            begin
                if (start_wr)
                begin
                    next_ctrl[BIT_WRITE_START] = 1'b1;
                    next_ctrl[BIT_WRITE_ERROR] = 1'b1;
                    next_timer = ERASE_COUNT;
                    next_state = ST_ERASE;
                end
                else if (start_rd)
                begin
                    next_ctrl[BIT_READ_START] = 1'b1;
                    next_state = ST_READ;
                end
            end
            ST_READ:
            begin
                if (ctrl[BIT_REGION_LO +: 2] == REGION_DATA)
                begin
                    next_data = mem[mem_addr];
                end
                else
                begin
                    next_data = ext_rdata;
                end
                next_ctrl[BIT_READ_START] = 1'b0;
                next_state = ST_IDLE;
            end
            ST_ERASE:
            begin
                if (timer == 16'h0000)
                begin
                    mem_we     = (ctrl[BIT_REGION_LO +: 2] == REGION_DATA);
                    mem_wdata  = ERASED_BYTE;
                    next_timer = PROG_COUNT;
                    next_state = ST_PROG;
                end
                else
                begin
                    next_timer = timer - 16'h0001;
                end
            end
            ST_PROG:
            begin
                if (timer == 16'h0000)
                begin
                    mem_we     = (ctrl[BIT_REGION_LO +: 2] == REGION_DATA);
                    next_state = ST_DONE;
                end
                else
                begin
                    next_timer = timer - 16'h0001;
                end
            end
            ST_DONE:
            begin
                next_ctrl[BIT_WRITE_START] = 1'b0;
                next_ctrl[BIT_WRITE_ERROR] = 1'b0;
                // Done flag set, wins over read clear
                next_status[BIT_DONE] = 1'b1;
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        next_irq = |(next_status & next_mask);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state   <= ST_IDLE;
            ctrl    <= RESET_BYTE;
            data    <= RESET_BYTE;
            addr_lo <= RESET_BYTE;
            addr_hi <= RESET_BYTE;
            unlock  <= RESET_BYTE;
            status  <= RESET_BYTE;
            mask    <= RESET_BYTE;
            timer   <= 16'h0000;
            rdata   <= RESET_BYTE;
            irq     <= 1'b0;
            region_out <= REGION_DATA;
        end
        else
        begin
            state   <= next_state;
            ctrl    <= next_ctrl;
            data    <= next_data;
            addr_lo <= next_addr_lo;
            addr_hi <= next_addr_hi;
            unlock  <= next_unlock;
            status  <= next_status;
            mask    <= next_mask;
            timer   <= next_timer;
            rdata   <= next_rdata;
            irq     <= next_irq;
            region_out <= next_ctrl[BIT_REGION_LO +: 2];
        end
    end

    // Array has no reset; contents are nonvolatile by intent
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_write_allow_reset: assert property (@(posedge clk)
        rst |=> !ctrl[BIT_WRITE_ALLOW]) else $error("allow not clear after reset");
    a_write_error_start: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl[BIT_WRITE_START]) |-> ctrl[BIT_WRITE_ERROR])
        else $error("error flag not set at start");
    a_write_start_held: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl[BIT_WRITE_START]) |-> ctrl[BIT_WRITE_START][*8])
        else $error("write start dropped early");
    a_write_duration: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl[BIT_WRITE_START]) |-> ##[100:102] !ctrl[BIT_WRITE_START])
        else $error("write cycle length wrong");
    a_done_on_finish: assert property (@(posedge clk) disable iff (rst)
        $fell(ctrl[BIT_WRITE_START]) |-> status[BIT_DONE])
        else $error("done flag missing");
    a_read_self_clear: assert property (@(posedge clk) disable iff (rst)
        ctrl[BIT_READ_START] |=> !ctrl[BIT_READ_START])
        else $error("read start stuck");
    a_prog_read_refused: assert property (@(posedge clk) disable iff (rst)
        ctrl[BIT_READ_START] |-> ctrl[BIT_REGION_LO +: 2] != REGION_PROG)
        else $error("program region read started");
    a_no_allow_ignored: assert property (@(posedge clk) disable iff (rst)
        (state == ST_IDLE && !ctrl[BIT_WRITE_ALLOW]) |=> state != ST_ERASE)
        else $error("write started without allow");
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(status & mask))
        else $error("irq mismatch");
    c_write: cover property (@(posedge clk) $fell(ctrl[BIT_WRITE_START]));
    c_read: cover property (@(posedge clk) $fell(ctrl[BIT_READ_START]));
    c_irq: cover property (@(posedge clk) $rose(irq));
endmodule

// [include/nvm_pkg.sv]
package nvm_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [2:0] OFS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_UNLOCK  = 3'h1;
    localparam logic [2:0] OFS_DATA    = 3'h2;
    localparam logic [2:0] OFS_ADDR_LO = 3'h3;
    localparam logic [2:0] OFS_ADDR_HI = 3'h4;
    localparam logic [2:0] OFS_STATUS  = 3'h5;
    localparam logic [2:0] OFS_MASK    = 3'h6;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int BIT_READ_START  = 0;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_WRITE_ALLOW = 2;
    localparam int BIT_WRITE_ERROR = 3;
    localparam int BIT_REGION_LO   = 6;
    localparam int BIT_DONE        = 0;

    localparam logic [1:0] REGION_DATA   = 2'h0;
    localparam logic [1:0] REGION_CONFIG = 2'h1;
    localparam logic [1:0] REGION_PROG   = 2'h2;

    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ       = 25;
    localparam int ERASE_TIME_US = 2;
    localparam int PROG_TIME_US  = 2;
    localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam logic [15:0] ERASE_COUNT = 16'(ERASE_CYCLES - 1);
    localparam logic [15:0] PROG_COUNT  = 16'(PROG_CYCLES - 1);

    localparam int DEPTH = 1024;
    localparam int AW    = 10;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_ERASE = 5'b00100,
        ST_PROG  = 5'b01000,
        ST_DONE  = 5'b10000
    } state_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

endpackage

// [verification/data_eeprom_access_control_test.sv]
module data_eeprom_access_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import nvm_pkg::*;

    // ****************************************************************
    // Signals and bench state
    // ****************************************************************
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    bus_req_t   bus       = '0;
    logic [7:0] ext_rdata = 8'h00;
    logic [7:0] rdata;
    logic       irq;
    logic [1:0] region_out;
    int         fail_count = 0;
    int         num_checks = 0;
    int         cycles     = 0;
    logic [7:0] seed       = 8'h33;
    int         mem[int];
    int         addrs[$];

    data_eeprom_access_control dut
    (
        .clk        (clk),
        .rst        (rst),
        .bus        (bus),
        .rdata      (rdata),
        .irq        (irq),
        .region_out (region_out),
        .ext_rdata  (ext_rdata)
    );

    always #20 clk = ~clk;

    // Ceiling well above the several hundred cycles the sequence needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic test_done();
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wait_clear(input logic [7:0] bits, input int start, output int took);
        logic [7:0] v;
        for (int n = 0; n < 200; n++)
        begin
            reg_rd(OFS_CONTROL, v);
            if ((v & bits) == 8'h00)
                break;
        end
        chk(v & bits, 8'h00, "start bit stuck");
        took = cycles - start;
    endtask

    task automatic set_addr(input int a);
        reg_wr(OFS_ADDR_LO, 8'(a));
        reg_wr(OFS_ADDR_HI, {6'h00, 2'(a >> 8)});
    endtask

    // ****************************************************************
    // Operations against the model
    // ****************************************************************
    task automatic do_write(input int a, input logic [7:0] d);
        logic [7:0] v;
        int         took;
        int         t0;
        set_addr(a);
        reg_wr(OFS_DATA, d);
        reg_wr(OFS_CONTROL, 8'h06);
        t0 = cycles;
        reg_rd(OFS_CONTROL, v);
        chk(v & 8'h0A, 8'h0A, "busy and error flags");
        // Error bit kept high so only the finish can clear it
        reg_wr(OFS_CONTROL, 8'h0C);
        reg_rd(OFS_CONTROL, v);
        chk(v & 8'h0A, 8'h0A, "start bit cleared by write");
        wait_clear(8'h02, t0, took);
        reg_rd(OFS_CONTROL, v);
        chk(v & 8'h0A, 8'h00, "flags after write");
        chk(8'(took >= ERASE_CYCLES + PROG_CYCLES), 8'h01, "write too short");
        // Polling granularity allows a few cycles of slack
        chk(8'(took <= ERASE_CYCLES + PROG_CYCLES + 6), 8'h01, "write too long");
        mem[a] = d;
    endtask

    task automatic do_read(input int a, input logic [1:0] region, input logic [7:0] exp);
        logic [7:0] v;
        int         took;
        set_addr(a);
        reg_wr(OFS_CONTROL, {region, 6'h05});
        wait_clear(8'h01, cycles, took);
        chk({6'h00, region_out}, {6'h00, region}, "region copy");
        reg_rd(OFS_DATA, v);
        chk(v, exp, "read byte");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [7:0] v;
        int         a;
        logic [7:0] d;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Every index reads zero after reset, the unmapped one too
        for (int i = 0; i < 8; i++)
        begin
            reg_rd(3'(i), v);
            chk(v, 8'h00, "reset value");
        end
        chk({7'h00, irq}, 8'h00, "irq after reset");
        reg_wr(OFS_CONTROL, 8'h04);
        for (int i = 0; i < 3; i++)
        begin
            seed = lfsr(seed);
            a = {seed[1:0], lfsr(seed)};
            seed = lfsr(lfsr(seed));
            d = seed;
            do_write(a, d);
            addrs.push_back(a);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({7'h00, irq}, {7'h00, i != 0}, "irq versus mask");
            reg_rd(OFS_STATUS, v);
            chk(v, 8'h01, "done flag held");
            reg_rd(OFS_STATUS, v);
            chk(v, 8'h00, "done flag after read");
            chk({7'h00, irq}, 8'h00, "irq after status read");
            reg_wr(OFS_MASK, 8'h01);
        end
        foreach (addrs[k])
            do_read(addrs[k], REGION_DATA, 8'(mem[addrs[k]]));
        // Start without allow leaves the byte and flags alone
        reg_wr(OFS_CONTROL, 8'h00);
        set_addr(addrs[0]);
        reg_wr(OFS_DATA, ~8'(mem[addrs[0]]));
        reg_wr(OFS_CONTROL, 8'h02);
        reg_rd(OFS_CONTROL, v);
        chk(v, 8'h00, "refused write start");
        repeat (120) @(posedge clk);
        reg_rd(OFS_STATUS, v);
        chk(v, 8'h00, "no done on refused write");
        do_read(addrs[0], REGION_DATA, 8'(mem[addrs[0]]));
        d = 8'(mem[addrs[0]]);
        for (int r = 1; r < 4; r++)
        begin
            seed = lfsr(seed);
            @(posedge clk);
            ext_rdata <= seed;
            // A refused program read leaves the data register alone
            if (2'(r) != REGION_PROG)
                d = seed;
            do_read(addrs[1], 2'(r), d);
        end
        test_done();
    end
endmodule
